// ==== src/rtc_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the clock core.
// Assumes: Included by bare name; definitions only.
// Notes:   Field macros are part-select ranges so they can sit inside brackets.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define RTC_OFF_WEEKDAY_HOUR    8'h00
`define RTC_OFF_MINUTE_SECOND   8'h04
`define RTC_OFF_ALARM_WEEKDAY   8'h08
`define RTC_OFF_ALARM_MINUTE_SECOND_VALUE    8'h0C
`define RTC_OFF_TRIM_CONFIG     8'h10
`define RTC_OFF_ALARM_CONFIG    8'h14

// ==========================================================================
// Field positions
`define RTC_WEEKDAY             10:8
`define RTC_HOUR_TENS           5:4
`define RTC_HOUR_ONES           3:0
`define RTC_HOUR_FIELD          5:0
`define RTC_MIN_TENS            14:12
`define RTC_MIN_ONES            11:8
`define RTC_MIN_FIELD           14:8
`define RTC_SEC_TENS            6:4
`define RTC_SEC_ONES            3:0
`define RTC_SEC_FIELD           6:0
`define RTC_CFG_RUN_BIT         15
`define RTC_CFG_UNLOCK_BIT      13
`define RTC_CFG_TRIM            7:0
`define RTC_ALM_ARM_BIT         15
`define RTC_ALM_MASK            13:10

// ==========================================================================
// Implemented bits, digit limits and reset values
`define RTC_WEEKDAY_HOUR_BITS   16'h073F
`define RTC_MINUTE_SECOND_BITS  16'h7F7F
`define RTC_TRIM_CONFIG_BITS    16'hA0FF
`define RTC_ALARM_CONFIG_BITS   16'hBC00
`define RTC_WEEKDAY_LAST        3'h6
`define RTC_ONES_LAST           4'h9
`define RTC_TENS_LAST           3'h5
`define RTC_HOUR_TENS_LAST      2'h2
`define RTC_HOUR_ONES_LAST_DAY  4'h3
`define RTC_REG_RESET           16'h0000

// ==========================================================================
// Timing
`define RTC_CLK_PERIOD_NS       8
`define RTC_CLK_HZ              (1000000000 / `RTC_CLK_PERIOD_NS)
`define RTC_XTAL_HZ             32768
`define RTC_XTAL_PER_SEC        32768
`define RTC_SECS_PER_MIN        60
`define RTC_CAL_PULSES_PER_UNIT 4

`endif

// ==== src/rtc_pkg.sv ====
// Purpose: Shared types of the clock core.
// Assumes: Constants live in rtc_defs.svh.
// Notes:   Nothing here is imported; users write rtc_pkg::name.
package rtc_pkg;

  // ==========================================================================
  // Bus answers and register selection
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_WEEKDAY_HOUR,
    SEL_MINUTE_SECOND,
    SEL_ALARM_WEEKDAY,
    SEL_ALARM_MINUTE_SECOND_VALUE,
    SEL_TRIM_CONFIG,
    SEL_ALARM_CONFIG
  } reg_sel_t;

endpackage

// ==== src/rtc_tick_if.sv ====
// Purpose: Carries run control, trim value and second pulse between core and prescaler.
// Assumes: Both ends run on aclk.
// Notes:   The prescaler drives only sec_pulse.
`timescale 1ns/1ns
`default_nettype none
interface rtc_tick_if;
  logic       run;
  logic [7:0] trim;
  logic       sec_pulse;

  modport ctrl  (output run, output trim, input sec_pulse);
  modport presc (input run, input trim, output sec_pulse);
endinterface
`default_nettype wire

// ==== src/rtc_prescaler.sv ====
// Purpose: Crystal-rate enable, one-second divider and per-minute trim correction.
// Assumes: aclk is the only clock; the crystal rate is a phase-accumulator enable.
// Notes:   A trim still pending at the next minute boundary is replaced.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_defs.svh"
module rtc_prescaler #(
  parameter int CLK_HZ        = `RTC_CLK_HZ,
  parameter int XTAL_HZ       = `RTC_XTAL_HZ,
  parameter int TICKS_PER_SEC = `RTC_XTAL_PER_SEC
) (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  rtc_tick_if.presc   tk
);

  localparam logic [31:0] CLK_W    = 32'(CLK_HZ);
  localparam logic [31:0] XTAL_W   = 32'(XTAL_HZ);
  localparam logic [15:0] TPS_LAST = 16'(TICKS_PER_SEC - 1);
  localparam logic [5:0]  MIN_LAST = 6'(`RTC_SECS_PER_MIN - 1);

  logic [31:0] phase_reg;
  logic [31:0] phase_sum;
  logic        xtal_en;
  logic [15:0] cnt_reg;
  logic [5:0]  secs_reg;
  logic [9:0]  pend_reg;
  logic        neg_reg;
  logic        pend_nz;
  logic        count_en;
  logic        pend_step;
  logic        wrap;
  logic        minute_end;
  logic        sec_pulse_reg;

  // Magnitude of the signed trim in crystal pulses.
  function automatic logic [9:0] trim_pulses(input logic [7:0] t);
    logic [7:0] mag;
    mag = t[7] ? 8'(~t + 8'h01) : t;
    return 10'(10'(mag) * 10'(`RTC_CAL_PULSES_PER_UNIT));
  endfunction

  // ==========================================================================
  // Crystal-rate enable
  assign phase_sum = phase_reg + XTAL_W;
  assign xtal_en   = phase_sum >= CLK_W;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= 32'h00000000;
    end else begin
      phase_reg <= xtal_en ? phase_sum - CLK_W : phase_sum;
    end
  end

  // Swallowed pulses land on crystal edges; inserted ones go in the gaps between them.
  assign pend_nz    = pend_reg != 10'h000;
  assign count_en   = tk.run && (xtal_en ? !(neg_reg && pend_nz) : (!neg_reg && pend_nz));
  assign pend_step  = tk.run && pend_nz && (neg_reg ? xtal_en : !xtal_en);
  assign wrap       = count_en && cnt_reg == TPS_LAST;
  assign minute_end = wrap && secs_reg == MIN_LAST;

  // ==========================================================================
  // Divider chain to one second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg       <= 16'h0000;
      sec_pulse_reg <= 1'b0;
    end else begin
      sec_pulse_reg <= wrap;
      if (wrap) begin
        cnt_reg <= 16'h0000;
      end else if (count_en) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
  assign tk.sec_pulse = sec_pulse_reg;

  // Seconds within the minute and the trim loaded at each minute boundary.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secs_reg <= 6'h00;
      pend_reg <= 10'h000;
      neg_reg  <= 1'b0;
    end else begin
      if (wrap) begin
        secs_reg <= (secs_reg == MIN_LAST) ? 6'h00 : secs_reg + 6'h01;
      end
      if (minute_end) begin
        pend_reg <= trim_pulses(tk.trim);
        neg_reg  <= tk.trim[7];
      end else if (pend_step) begin
        pend_reg <= pend_reg - 10'h001;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sec_pulse_a: assert property (wrap |=> tk.sec_pulse ##1 !tk.sec_pulse)
    else $error("second pulse does not follow divider wrap");
  trim_load_a: assert property (minute_end |=> pend_reg == trim_pulses($past(tk.trim)))
    else $error("minute trim not loaded as four pulses per unit");
  swallow_a: assert property (tk.run && neg_reg && pend_nz && xtal_en && !minute_end
                              |=> $stable(cnt_reg) && pend_reg == $past(pend_reg) - 10'h001)
    else $error("negative trim did not swallow a crystal pulse");
  insert_a: assert property (tk.run && !neg_reg && pend_nz && !xtal_en && cnt_reg != TPS_LAST
                             |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("positive trim did not insert a pulse");

endmodule
`default_nettype wire

// ==== src/rtc_core.sv ====
// Purpose: Weekday/time counter, alarm compare and trim control behind an AXI4-Lite slave.
// Assumes: Single clock aclk; synchronous active-low reset; one access per channel at a time.
// Notes:   Alarm request is a one-cycle pulse; no interrupt status is kept here.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_defs.svh"
// Contract
// - weekday in bits 10:8, values 0 to 6
// - hour tens in bits 5:4, 0 to 2
// - hour ones in bits 3:0, 0 to 9
// - minute tens in bits 14:12, 0 to 5
// - minute ones in bits 11:8, 0 to 9
// - second tens in bits 6:4, 0 to 5
// - second ones in bits 3:0, 0 to 9
// - unimplemented bits read back as zero
// - weekday/hour writes need the unlock bit set
// - signed 8-bit trim applied once per minute
// - one trim unit equals four crystal pulses
// - negative trim removes pulses each minute
// - positive trim inserts pulses each minute
// - alarm fires when masked digits match time
// - alarm arm clears itself when alarm fires
// - every alarm event raises an interrupt request
module rtc_core #(
  parameter int CLK_HZ        = `RTC_CLK_HZ,
  parameter int XTAL_HZ       = `RTC_XTAL_HZ,
  parameter int TICKS_PER_SEC = `RTC_XTAL_PER_SEC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             alarm_irq,
  output logic             alarm_pulse_out
);

  logic [15:0]         wh_reg;
  logic [15:0]         ms_reg;
  logic [15:0]         al_wh_reg;
  logic [15:0]         al_ms_reg;
  logic [15:0]         trim_cfg_reg;
  logic [15:0]         alarm_cfg_reg;
  logic [31:0]         advanced;
  logic [15:0]         wdata16;
  logic [1:0]          wstrb16;
  logic                wr_fire;
  logic                rd_fire;
  rtc_pkg::reg_sel_t   wr_sel;
  rtc_pkg::reg_sel_t   rd_sel;
  logic                unlock;
  logic                wh_wr;
  logic                ms_wr;
  logic                sec_tick;
  logic                tick_d_reg;
  logic                match;
  logic                fire;
  logic                irq_reg;
  logic                pulse_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                rvalid_reg;
  logic [1:0]          rresp_reg;
  logic [31:0]         rdata_reg;

  rtc_tick_if tk ();

  // Decodes a byte address to a register; unaligned or unknown is no register.
  function automatic rtc_pkg::reg_sel_t decode(input logic [7:0] addr);
    case (addr)
      `RTC_OFF_WEEKDAY_HOUR:  return rtc_pkg::SEL_WEEKDAY_HOUR;
      `RTC_OFF_MINUTE_SECOND: return rtc_pkg::SEL_MINUTE_SECOND;
      `RTC_OFF_ALARM_WEEKDAY: return rtc_pkg::SEL_ALARM_WEEKDAY;
      `RTC_OFF_ALARM_MINUTE_SECOND_VALUE:  return rtc_pkg::SEL_ALARM_MINUTE_SECOND_VALUE;
      `RTC_OFF_TRIM_CONFIG:   return rtc_pkg::SEL_TRIM_CONFIG;
      `RTC_OFF_ALARM_CONFIG:  return rtc_pkg::SEL_ALARM_CONFIG;
      default:                return rtc_pkg::SEL_NONE;
    endcase
  endfunction

  // Applies byte enables to a 16-bit register and drops unimplemented bits.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] bits);
    logic [15:0] v;
    v = old;
    if (wstrb16[0]) begin
      v[7:0] = wdata16[7:0];
    end
    if (wstrb16[1]) begin
      v[15:8] = wdata16[15:8];
    end
    return v & bits;
  endfunction

  // Advances the packed weekday/hour and minute/second words by one second.
  function automatic logic [31:0] advance(input logic [15:0] wh, input logic [15:0] ms);
    logic [3:0] so;
    logic [2:0] st;
    logic [3:0] mo;
    logic [2:0] mt;
    logic [3:0] ho;
    logic [1:0] ht;
    logic [2:0] wd;
    logic       c;
    so = ms[`RTC_SEC_ONES];
    st = ms[`RTC_SEC_TENS];
    mo = ms[`RTC_MIN_ONES];
    mt = ms[`RTC_MIN_TENS];
    ho = wh[`RTC_HOUR_ONES];
    ht = wh[`RTC_HOUR_TENS];
    wd = wh[`RTC_WEEKDAY];
    c = 1'b1;
    if (so >= `RTC_ONES_LAST) begin
      so = 4'h0;
    end else begin
      so = so + 4'h1;
      c = 1'b0;
    end
    if (c) begin
      if (st >= `RTC_TENS_LAST) begin
        st = 3'h0;
      end else begin
        st = st + 3'h1;
        c = 1'b0;
      end
    end
    if (c) begin
      if (mo >= `RTC_ONES_LAST) begin
        mo = 4'h0;
      end else begin
        mo = mo + 4'h1;
        c = 1'b0;
      end
    end
    if (c) begin
      if (mt >= `RTC_TENS_LAST) begin
        mt = 3'h0;
      end else begin
        mt = mt + 3'h1;
        c = 1'b0;
      end
    end
    if (c) begin
      if (ht >= `RTC_HOUR_TENS_LAST && ho >= `RTC_HOUR_ONES_LAST_DAY) begin
        ht = 2'h0;
        ho = 4'h0;
      end else if (ho >= `RTC_ONES_LAST) begin
        ho = 4'h0;
        ht = ht + 2'h1;
        c = 1'b0;
      end else begin
        ho = ho + 4'h1;
        c = 1'b0;
      end
    end
    if (c) begin
      wd = (wd >= `RTC_WEEKDAY_LAST) ? 3'h0 : wd + 3'h1;
    end
    return {5'h00, wd, 2'h0, ht, ho, 1'b0, mt, mo, 1'b0, st, so};
  endfunction

  // ==========================================================================
  // Prescaler and control wiring
  assign unlock   = trim_cfg_reg[`RTC_CFG_UNLOCK_BIT];
  assign tk.run   = trim_cfg_reg[`RTC_CFG_RUN_BIT];
  assign tk.trim  = trim_cfg_reg[`RTC_CFG_TRIM];
  assign sec_tick = tk.sec_pulse;

  rtc_prescaler #(
    .CLK_HZ        (CLK_HZ),
    .XTAL_HZ       (XTAL_HZ),
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tk      (tk)
  );

  // ==========================================================================
  // Write channel: address and data are taken together, answer one cycle later.
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign wr_sel        = decode(s_axi_awaddr);
  assign wdata16       = s_axi_wdata[15:0];
  assign wstrb16       = s_axi_wstrb[1:0];
  assign wh_wr         = wr_fire && wr_sel == rtc_pkg::SEL_WEEKDAY_HOUR && unlock;
  assign ms_wr         = wr_fire && wr_sel == rtc_pkg::SEL_MINUTE_SECOND;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= rtc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_sel == rtc_pkg::SEL_NONE) ? rtc_pkg::RESP_SLVERR : rtc_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ==========================================================================
  // Time registers: a software write wins over the second tick in the same cycle.
  assign advanced = advance(wh_reg, ms_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wh_reg <= `RTC_REG_RESET;
      ms_reg <= `RTC_REG_RESET;
    end else begin
      if (wh_wr) begin
        wh_reg <= merge(wh_reg, `RTC_WEEKDAY_HOUR_BITS);
      end else if (sec_tick) begin
        wh_reg <= advanced[31:16];
      end
      if (ms_wr) begin
        ms_reg <= merge(ms_reg, `RTC_MINUTE_SECOND_BITS);
      end else if (sec_tick) begin
        ms_reg <= advanced[15:0];
      end
    end
  end

  // Alarm value and configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      al_wh_reg    <= `RTC_REG_RESET;
      al_ms_reg    <= `RTC_REG_RESET;
      trim_cfg_reg <= `RTC_REG_RESET;
    end else if (wr_fire) begin
      if (wr_sel == rtc_pkg::SEL_ALARM_WEEKDAY && unlock) begin
        al_wh_reg <= merge(al_wh_reg, `RTC_WEEKDAY_HOUR_BITS);
      end
      if (wr_sel == rtc_pkg::SEL_ALARM_MINUTE_SECOND_VALUE) begin
        al_ms_reg <= merge(al_ms_reg, `RTC_MINUTE_SECOND_BITS);
      end
      if (wr_sel == rtc_pkg::SEL_TRIM_CONFIG) begin
        trim_cfg_reg <= merge(trim_cfg_reg, `RTC_TRIM_CONFIG_BITS);
      end
    end
  end

  // ==========================================================================
  // Alarm compare one cycle after the tick, on the freshly advanced time.
  assign match = (!alarm_cfg_reg[10] || al_ms_reg[`RTC_SEC_FIELD] == ms_reg[`RTC_SEC_FIELD]) &&
                 (!alarm_cfg_reg[11] || al_ms_reg[`RTC_MIN_FIELD] == ms_reg[`RTC_MIN_FIELD]) &&
                 (!alarm_cfg_reg[12] || al_wh_reg[`RTC_HOUR_FIELD] == wh_reg[`RTC_HOUR_FIELD]) &&
                 (!alarm_cfg_reg[13] || al_wh_reg[`RTC_WEEKDAY] == wh_reg[`RTC_WEEKDAY]);
  assign fire  = alarm_cfg_reg[`RTC_ALM_ARM_BIT] && tick_d_reg && match;

  // Arm and mask; a software write in the firing cycle wins over the auto-clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_cfg_reg <= `RTC_REG_RESET;
    end else if (wr_fire && wr_sel == rtc_pkg::SEL_ALARM_CONFIG) begin
      alarm_cfg_reg <= merge(alarm_cfg_reg, `RTC_ALARM_CONFIG_BITS);
    end else if (fire) begin
      alarm_cfg_reg[`RTC_ALM_ARM_BIT] <= 1'b0;
    end
  end

  // Request pulse per event and a pulse output at half the alarm rate.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_d_reg <= 1'b0;
      irq_reg    <= 1'b0;
      pulse_reg  <= 1'b0;
    end else begin
      tick_d_reg <= sec_tick;
      irq_reg    <= fire;
      if (fire) begin
        pulse_reg <= !pulse_reg;
      end
    end
  end
  assign alarm_irq       = irq_reg;
  assign alarm_pulse_out = pulse_reg;

  // ==========================================================================
  // Read channel: data registered one cycle after the address is taken.
  assign rd_fire       = s_axi_arvalid && !rvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign rd_sel        = decode(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= rtc_pkg::RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= (rd_sel == rtc_pkg::SEL_NONE) ? rtc_pkg::RESP_SLVERR : rtc_pkg::RESP_OKAY;
      case (rd_sel)
        rtc_pkg::SEL_WEEKDAY_HOUR:  rdata_reg <= {16'h0000, wh_reg};
        rtc_pkg::SEL_MINUTE_SECOND: rdata_reg <= {16'h0000, ms_reg};
        rtc_pkg::SEL_ALARM_WEEKDAY: rdata_reg <= {16'h0000, al_wh_reg};
        rtc_pkg::SEL_ALARM_MINUTE_SECOND_VALUE:  rdata_reg <= {16'h0000, al_ms_reg};
        rtc_pkg::SEL_TRIM_CONFIG:   rdata_reg <= {16'h0000, trim_cfg_reg};
        rtc_pkg::SEL_ALARM_CONFIG:  rdata_reg <= {16'h0000, alarm_cfg_reg};
        default:                    rdata_reg <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence quiet_tick_s;
    sec_tick && !wh_wr && !ms_wr;
  endsequence
  sequence end_of_day_s;
    quiet_tick_s ##0 (ms_reg == 16'h5959 && wh_reg[`RTC_HOUR_FIELD] == 6'h23);
  endsequence

  lock_guard_a: assert property (wr_fire && wr_sel == rtc_pkg::SEL_WEEKDAY_HOUR && !unlock && !sec_tick
                                 |=> $stable(wh_reg))
    else $error("locked weekday/hour write changed the register");
  reserved_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 &&
                                    (wh_reg & ~`RTC_WEEKDAY_HOUR_BITS) == 16'h0000 &&
                                    (ms_reg & ~`RTC_MINUTE_SECOND_BITS) == 16'h0000)
    else $error("unimplemented bits are not zero");
  weekday_wrap_a: assert property (end_of_day_s ##0 wh_reg[`RTC_WEEKDAY] == 3'h6
                                   |=> wh_reg[`RTC_WEEKDAY] == 3'h0)
    else $error("weekday did not wrap after six");
  hour_wrap_a: assert property (end_of_day_s |=> wh_reg[`RTC_HOUR_FIELD] == 6'h00 && ms_reg == 16'h0000)
    else $error("hours did not wrap after 23:59:59");
  minute_roll_a: assert property (quiet_tick_s ##0 ms_reg == 16'h5959 |=> ms_reg == 16'h0000 &&
                                  wh_reg != $past(wh_reg))
    else $error("minutes did not roll into hours");
  second_roll_a: assert property (quiet_tick_s ##0 ms_reg[`RTC_SEC_FIELD] == 7'h59 &&
                                  ms_reg[`RTC_MIN_ONES] < 4'h9
                                  |=> ms_reg[`RTC_SEC_FIELD] == 7'h00 &&
                                      ms_reg[`RTC_MIN_ONES] == $past(ms_reg[`RTC_MIN_ONES]) + 4'h1)
    else $error("seconds did not roll into minutes");
  advance_a: assert property (!sec_tick && !wh_wr && !ms_wr |=> $stable(ms_reg) && $stable(wh_reg))
    else $error("time moved without a second tick");
  match_fire_a: assert property (alarm_cfg_reg[`RTC_ALM_ARM_BIT] && tick_d_reg && match
                                 |=> alarm_irq ##1 !alarm_irq)
    else $error("matching armed alarm gave no single request pulse");
  disarm_a: assert property (fire && !(wr_fire && wr_sel == rtc_pkg::SEL_ALARM_CONFIG)
                             |=> !alarm_cfg_reg[`RTC_ALM_ARM_BIT] [*2])
    else $error("alarm arm not cleared after firing");
  irq_cause_a: assert property ($rose(alarm_irq) |-> $past(fire) && $changed(alarm_pulse_out))
    else $error("request without an alarm event");

endmodule
`default_nettype wire

// ==== bench/rtc_time_alarm_calibration_tb_top.sv ====
// Purpose: Self-checking bench of the clock core over AXI4-Lite.
// Assumes: Short counts: a second is 32 aclk cycles.
// Notes:   Trim checks accept a window, as minute phase varies.
`timescale 1ns/1ns
`default_nettype none
module rtc_time_alarm_calibration_tb_top;
  // ======
  // Bench signals
  logic        aclk = '0, aresetn = '0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic        awready, wready, bvalid, arready, rvalid, irq, pout;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] d, m;
  logic [3:0]  wstrb = 4'hF, w;
  logic [2:0]  prot = '0;
  int          error_cnt = 0, cmp_count = 0, s, n;

  rtc_core #(.CLK_HZ(4), .XTAL_HZ(2), .TICKS_PER_SEC(16)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .alarm_irq(irq),
    .alarm_pulse_out(pout));

  // Clock of 8 ns period.
  always #4 aclk = ~aclk;

  // ======
  // Bus tasks: ready is looked at on the falling edge, so the next rising edge is the handshake.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    @(negedge aclk);
    while (awready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    @(negedge aclk);
    while (bvalid !== 1'b1) @(negedge aclk);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(negedge aclk);
    while (arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    m = rdata[15:0];
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog cuts a hang short.
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  // ======
  // Main sequence.
  initial begin
    void'($urandom(32'hA5F4E8A5));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      chk("reset value", 32'h0, {r, m});
    end
    rd(8'h18);
    chk("unmapped read", 32'h20000, {r, m});
    wr(8'h18, 16'h1234);
    chk("unmapped write", 32'h2, {30'h0, r});
    wr(8'h00, 16'h0512);
    chk("write response", 32'h0, {30'h0, r});
    rd(8'h00);
    chk("locked write", 32'h0, {r, m});
    wr(8'h10, 16'h2000);
    // Registers still hold zero here, so only the enabled and implemented bits of d come back.
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 16'hFFFF : 16'($urandom);
      w = (i == 0) ? 4'hF : 4'($urandom);
      wstrb <= w;
      prot  <= 3'($urandom);
      wr(8'(i * 4), d);
      rd(8'(i * 4));
      d = d & {{8{w[1]}}, {8{w[0]}}} & (i[0] ? 16'h7F7F : 16'h073F);
      chk("field mask", {16'h0, d}, {r, m});
    end
    wstrb <= 4'hF;
    wr(8'h00, 16'h0623);
    wr(8'h04, 16'h5959);
    wr(8'h10, 16'hA000);
    repeat (40) @(posedge aclk);
    wr(8'h10, 16'h2000);
    rd(8'h00);
    chk("weekday wrap", 32'h0, {r, m});
    rd(8'h04);
    chk("minute wrap", 32'h0, {r, m});
    wr(8'h0C, 16'h0002);
    wr(8'h14, 16'h8400);
    wr(8'h10, 16'hA000);
    // First pass matches seconds only, the second pass compares every digit group.
    for (int j = 0; j < 2; j++) begin
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
        @(negedge aclk);
        n++;
      end
      chk("alarm request", 32'h1, {31'h0, irq});
      rd(8'h04);
      chk("alarm time", j ? 32'h4 : 32'h2, {r, m});
      rd(8'h14);
      chk("arm cleared", j ? 32'h3C00 : 32'h0400, {r, m});
      chk("alarm pulse out", j ? 32'h0 : 32'h1, {31'h0, pout});
      if (j == 0) begin
        wr(8'h08, 16'h0000);
        wr(8'h0C, 16'h0004);
        wr(8'h14, 16'hBC00);
      end
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h04, 16'h0000);
      wr(8'h10, k ? 16'hA0E0 : 16'hA020);
      repeat (3900) @(posedge aclk);
      wr(8'h10, 16'h2000);
      rd(8'h04);
      s = m[14:12] * 600 + m[11:8] * 60 + m[6:4] * 10 + m[3:0];
      chk("trimmed seconds", 32'h1, {31'h0, k ? (s >= 100 && s <= 118) : (s >= 130 && s <= 150)});
    end
    complete_run();
  end
endmodule
`default_nettype wire
